// ### design/pmc_map.svh
// Register offsets, field positions, reset values and clock counts of the port block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define PMC_OFS_PC_DATA 8'h00
`define PMC_OFS_PC_DIR 8'h01
`define PMC_OFS_PC_OPT 8'h02
`define PMC_OFS_PB_DATA 8'h04
`define PMC_OFS_PB_DIR 8'h05
`define PMC_OFS_PB_OPT 8'h06
`define PMC_OFS_PA_DATA 8'h08
`define PMC_OFS_PA_DIR 8'h09
`define PMC_OFS_PA_OPT 8'h0A
`define PMC_OFS_MISC1 8'h20
`define PMC_OFS_MISC2 8'h40

// ****************************************
// Reset values
// ****************************************
`define PMC_RST_PORT 8'h00
`define PMC_RST_MISC1 8'h00
`define PMC_RST_MISC2 4'h0

// ****************************************
// Field positions
// ****************************************
`define PMC_M1_SENS1_HI 7
`define PMC_M1_SENS1_LO 6
`define PMC_M1_CLKOUT 5
`define PMC_M1_SENS0_HI 4
`define PMC_M1_SENS0_LO 3
`define PMC_M1_PRESC_HI 2
`define PMC_M1_PRESC_LO 1
`define PMC_M1_SLOW 0
`define PMC_M2_MOSI_DIS 3
`define PMC_M2_MISO_DIS 2
`define PMC_M2_SS_SRC 1
`define PMC_M2_SS_INT 0
`define PMC_M2_WIDTH 4
`define PMC_CLKOUT_PIN 2
`define PMC_SS_PIN 7
// Port A pins with no option bit (true open drain)
`define PMC_PA_NO_OPT 8'h50

// ****************************************
// Clock divider terminal counts (half period minus one)
// ****************************************
`define PMC_TERM_DIV2 5'h00
`define PMC_TERM_DIV4 5'h01
`define PMC_TERM_DIV8 5'h03
`define PMC_TERM_DIV16 5'h07
`define PMC_TERM_DIV32 5'h0F

`endif

// ### design/pmc_pkg.sv
// Types shared by the port configuration block
package pmc_pkg;

    // Interrupt sensitivity encodings
    typedef enum logic [1:0] {
        PMC_SENS_FALL_LOW = 2'b00,
        PMC_SENS_RISE = 2'b01,
        PMC_SENS_FALL = 2'b10,
        PMC_SENS_BOTH = 2'b11
    } pmc_sens_type;

    // Whole state of the block; index 0 = port A, 1 = port B, 2 = port C
    typedef struct packed {
        logic [2:0][7:0] data;
        logic [2:0][7:0] dir;
        logic [2:0][7:0] opt;
        logic [2:0][7:0] sync1;
        logic [2:0][7:0] sync2;
        logic [2:0][7:0] sync3;
        logic [2:0][7:0] filt;
        logic [2:0][7:0] prev;
        logic [7:0] misc1;
        logic [3:0] misc2;
        logic [7:0] rdata;
        logic [4:0] div_cnt;
        logic cpu_clk;
        logic [2:0][7:0] pin_out;
        logic [2:0][7:0] pin_oe;
        logic [2:0][7:0] pull_up;
        logic irq0;
        logic irq1;
        logic spi_ss;
    } pmc_state_type;

endpackage : pmc_pkg

// ### design/pmc_port_ctrl.sv
// Port configuration, external interrupt sensitivity and miscellaneous control
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_map.svh"

// Overview of operation
// - Direction bit: 0 input, 1 output
// - Input option: 0 floating, 1 pull-up
// - Output option: 0 open drain, 1 push-pull
// - Pins lacking option use direction only
// - All port registers reset to zero
// - Bits 7:6 set group 1 sensitivity
// - Bits 4:3 set group 0 sensitivity
// - Sensitivity writable only while interrupts masked
// - Independent groups; option picks port C group
// - Clock-out bit drives CPU clock on pin
// - Prescaler field picks slow divisor 4..32
// - Slow select 0 gives divide by two
// - Master output disable bit suppresses MOSI
// - Slave output disable bit suppresses MISO
// - Slave-select source: pin or internal bit
// - Internal bit replaces slave-select, pin free
// - Upper four control-two bits read zero
// - Interrupt only from capable pin, unmasked CPU
// - Data read: latch for outputs, pin otherwise
module pmc_port_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // CPU status and option strap
    input wire logic irq_mask_i,
    input wire logic irq_source_option_bit_i,
    // Port A pins
    input wire logic [7:0] pa_in_i,
    output logic [7:0] pa_out_o,
    output logic [7:0] pa_oe_o,
    output logic [7:0] pa_pullup_o,
    // Port B pins
    input wire logic [7:0] pb_in_i,
    output logic [7:0] pb_out_o,
    output logic [7:0] pb_oe_o,
    output logic [7:0] pb_pullup_o,
    // Port C pins
    input wire logic [7:0] pc_in_i,
    output logic [7:0] pc_out_o,
    output logic [7:0] pc_oe_o,
    output logic [7:0] pc_pullup_o,
    // External interrupt requests
    output logic ext_irq_group0_o,
    output logic ext_irq_group1_o,
    // Clock control
    output logic cpu_clk_o,
    // SPI pin control
    output logic spi_mosi_disable_o,
    output logic spi_miso_disable_o,
    output logic spi_ss_o
);

    // ****************************************
    // State
    // ****************************************
    pmc_pkg::pmc_state_type st_q;
    pmc_pkg::pmc_state_type st_d;

    logic [2:0][7:0] no_opt;
    logic [2:0][7:0] cap;
    logic [15:0] g0_cap;
    logic [15:0] g1_cap;
    logic [15:0] g0_now;
    logic [15:0] g0_old;
    logic [15:0] g1_now;
    logic [15:0] g1_old;
    logic [4:0] div_term;

    assign no_opt = {8'h00, 8'h00, `PMC_PA_NO_OPT};

    // Request of one group for its sensitivity
    function automatic logic grp_req(input logic [1:0] sens, input logic [15:0] capm,
                                     input logic [15:0] now, input logic [15:0] old);
        logic fall;
        logic rise;
        logic low;
        fall = |(capm & old & ~now);
        rise = |(capm & ~old & now);
        low = |(capm & ~now);
        case (pmc_pkg::pmc_sens_type'(sens))
            pmc_pkg::PMC_SENS_FALL_LOW: grp_req = fall | low;
            pmc_pkg::PMC_SENS_RISE: grp_req = rise;
            pmc_pkg::PMC_SENS_FALL: grp_req = fall;
            pmc_pkg::PMC_SENS_BOTH: grp_req = fall | rise;
            default: grp_req = 1'b0;
        endcase
    endfunction : grp_req

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;

        // Pin sampling: a change counts once the last two stages agree
        st_d.sync1 = {pc_in_i, pb_in_i, pa_in_i};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (st_q.sync2[p][b] == st_q.sync3[p][b]) begin
                    st_d.filt[p][b] = st_q.sync3[p][b];
                end
            end
        end
        st_d.prev = st_q.filt;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                `PMC_OFS_PA_DATA: st_d.data[0] = wdata_i;
                `PMC_OFS_PA_DIR: st_d.dir[0] = wdata_i;
                `PMC_OFS_PA_OPT: st_d.opt[0] = wdata_i & ~no_opt[0];
                `PMC_OFS_PB_DATA: st_d.data[1] = wdata_i;
                `PMC_OFS_PB_DIR: st_d.dir[1] = wdata_i;
                `PMC_OFS_PB_OPT: st_d.opt[1] = wdata_i & ~no_opt[1];
                `PMC_OFS_PC_DATA: st_d.data[2] = wdata_i;
                `PMC_OFS_PC_DIR: st_d.dir[2] = wdata_i;
                `PMC_OFS_PC_OPT: st_d.opt[2] = wdata_i & ~no_opt[2];
                `PMC_OFS_MISC1: begin
                    st_d.misc1[`PMC_M1_CLKOUT] = wdata_i[`PMC_M1_CLKOUT];
                    st_d.misc1[`PMC_M1_PRESC_HI:`PMC_M1_PRESC_LO] =
                        wdata_i[`PMC_M1_PRESC_HI:`PMC_M1_PRESC_LO];
                    st_d.misc1[`PMC_M1_SLOW] = wdata_i[`PMC_M1_SLOW];
                    // Changing sensitivity with interrupts open could fire spuriously
                    if (irq_mask_i) begin
                        st_d.misc1[`PMC_M1_SENS1_HI:`PMC_M1_SENS1_LO] =
                            wdata_i[`PMC_M1_SENS1_HI:`PMC_M1_SENS1_LO];
                        st_d.misc1[`PMC_M1_SENS0_HI:`PMC_M1_SENS0_LO] =
                            wdata_i[`PMC_M1_SENS0_HI:`PMC_M1_SENS0_LO];
                    end
                end
                `PMC_OFS_MISC2: st_d.misc2 = wdata_i[`PMC_M2_WIDTH-1:0];
                default: ;
            endcase
        end

        // Register reads, answered one cycle later
        st_d.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `PMC_OFS_PA_DATA:
                    st_d.rdata = (st_q.dir[0] & st_q.data[0]) | (~st_q.dir[0] & st_q.filt[0]);
                `PMC_OFS_PA_DIR: st_d.rdata = st_q.dir[0];
                `PMC_OFS_PA_OPT: st_d.rdata = st_q.opt[0];
                `PMC_OFS_PB_DATA:
                    st_d.rdata = (st_q.dir[1] & st_q.data[1]) | (~st_q.dir[1] & st_q.filt[1]);
                `PMC_OFS_PB_DIR: st_d.rdata = st_q.dir[1];
                `PMC_OFS_PB_OPT: st_d.rdata = st_q.opt[1];
                `PMC_OFS_PC_DATA:
                    st_d.rdata = (st_q.dir[2] & st_q.data[2]) | (~st_q.dir[2] & st_q.filt[2]);
                `PMC_OFS_PC_DIR: st_d.rdata = st_q.dir[2];
                `PMC_OFS_PC_OPT: st_d.rdata = st_q.opt[2];
                `PMC_OFS_MISC1: st_d.rdata = st_q.misc1;
                `PMC_OFS_MISC2: st_d.rdata = {4'h0, st_q.misc2};
                default: st_d.rdata = 8'h00;
            endcase
        end

        // Pin drive
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (st_q.dir[p][b]) begin
                    if (st_q.opt[p][b]) begin
                        st_d.pin_out[p][b] = st_q.data[p][b];
                        st_d.pin_oe[p][b] = 1'b1;
                    end else begin
                        // Open drain: only a low is driven
                        st_d.pin_out[p][b] = 1'b0;
                        st_d.pin_oe[p][b] = ~st_q.data[p][b];
                    end
                    st_d.pull_up[p][b] = 1'b0;
                end else begin
                    st_d.pin_out[p][b] = 1'b0;
                    st_d.pin_oe[p][b] = 1'b0;
                    st_d.pull_up[p][b] = st_q.opt[p][b];
                end
            end
        end
        if (st_q.misc1[`PMC_M1_CLKOUT]) begin
            st_d.pin_out[2][`PMC_CLKOUT_PIN] = st_q.cpu_clk;
            st_d.pin_oe[2][`PMC_CLKOUT_PIN] = 1'b1;
            st_d.pull_up[2][`PMC_CLKOUT_PIN] = 1'b0;
        end

        // CPU clock divider
        if (!st_q.misc1[`PMC_M1_SLOW]) begin
            div_term = `PMC_TERM_DIV2;
        end else begin
            case (st_q.misc1[`PMC_M1_PRESC_HI:`PMC_M1_PRESC_LO])
                2'b00: div_term = `PMC_TERM_DIV4;
                2'b10: div_term = `PMC_TERM_DIV8;
                2'b01: div_term = `PMC_TERM_DIV16;
                2'b11: div_term = `PMC_TERM_DIV32;
                default: div_term = `PMC_TERM_DIV2;
            endcase
        end
        // Counting past a shortened terminal toggles at once, so a new ratio acts fast
        if (st_q.div_cnt >= div_term) begin
            st_d.div_cnt = 5'h00;
            st_d.cpu_clk = ~st_q.cpu_clk;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 5'h01;
        end

        // External interrupt groups; port C joins the group the strap picks
        for (int p = 0; p < 3; p++) begin
            cap[p] = ~st_q.dir[p] & st_q.opt[p];
        end
        g0_cap = {irq_source_option_bit_i ? 8'h00 : cap[2], cap[0]};
        g1_cap = {irq_source_option_bit_i ? cap[2] : 8'h00, cap[1]};
        g0_now = {st_q.filt[2], st_q.filt[0]};
        g0_old = {st_q.prev[2], st_q.prev[0]};
        g1_now = {st_q.filt[2], st_q.filt[1]};
        g1_old = {st_q.prev[2], st_q.prev[1]};
        st_d.irq0 = ~irq_mask_i & grp_req(st_q.misc1[`PMC_M1_SENS0_HI:`PMC_M1_SENS0_LO],
                                          g0_cap, g0_now, g0_old);
        st_d.irq1 = ~irq_mask_i & grp_req(st_q.misc1[`PMC_M1_SENS1_HI:`PMC_M1_SENS1_LO],
                                          g1_cap, g1_now, g1_old);

        // Slave select source; the pin itself stays ordinary I/O
        st_d.spi_ss = st_q.misc2[`PMC_M2_SS_SRC] ? st_q.misc2[`PMC_M2_SS_INT]
                                                 : st_q.filt[1][`PMC_SS_PIN];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_o = st_q.rdata;
    assign pa_out_o = st_q.pin_out[0];
    assign pa_oe_o = st_q.pin_oe[0];
    assign pa_pullup_o = st_q.pull_up[0];
    assign pb_out_o = st_q.pin_out[1];
    assign pb_oe_o = st_q.pin_oe[1];
    assign pb_pullup_o = st_q.pull_up[1];
    assign pc_out_o = st_q.pin_out[2];
    assign pc_oe_o = st_q.pin_oe[2];
    assign pc_pullup_o = st_q.pull_up[2];
    assign ext_irq_group0_o = st_q.irq0;
    assign ext_irq_group1_o = st_q.irq1;
    assign cpu_clk_o = st_q.cpu_clk;
    assign spi_mosi_disable_o = st_q.misc2[`PMC_M2_MOSI_DIS];
    assign spi_miso_disable_o = st_q.misc2[`PMC_M2_MISO_DIS];
    assign spi_ss_o = st_q.spi_ss;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_push_pull_drive: assert property (
        st_q.dir[1][0] && st_q.opt[1][0] |=> pb_oe_o[0] && pb_out_o[0] == $past(st_q.data[1][0]))
        else $error("push-pull output not driven");
    a_open_drain_high: assert property (
        st_q.dir[1][3] && !st_q.opt[1][3] && st_q.data[1][3] |=> !pb_oe_o[3])
        else $error("open drain drives high");
    a_input_pullup: assert property (
        !st_q.dir[2][5] |=> !pc_oe_o[5] && pc_pullup_o[5] == $past(st_q.opt[2][5]))
        else $error("input pull-up wrong");
    a_no_option_bit: assert property (
        wr_i && addr_i == `PMC_OFS_PA_OPT |=> st_q.opt[0][6] == 1'b0 && st_q.opt[0][4] == 1'b0)
        else $error("missing option bit got set");
    a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
        !rst_n_i |=> st_q.dir == '0 && st_q.opt == '0 && st_q.data == '0)
        else $error("port registers not cleared");
    a_sens_locked: assert property (
        wr_i && addr_i == `PMC_OFS_MISC1 && !irq_mask_i |=>
        st_q.misc1[7:6] == $past(st_q.misc1[7:6]) && st_q.misc1[4:3] == $past(st_q.misc1[4:3]))
        else $error("sensitivity changed while unmasked");
    a_low_level_hold: assert property (
        st_q.misc1[4:3] == 2'b00 && !irq_mask_i && |(~st_q.dir[0] & st_q.opt[0] & ~st_q.filt[0])
        |=> ext_irq_group0_o)
        else $error("low level request missing");
    a_rise_pulse: assert property (
        st_q.misc1[7:6] == 2'b01 && !irq_mask_i &&
        |(~st_q.dir[1] & st_q.opt[1] & ~st_q.prev[1] & st_q.filt[1]) |=> ext_irq_group1_o)
        else $error("rising edge request missing");
    a_masked_quiet: assert property (
        irq_mask_i |=> !ext_irq_group0_o && !ext_irq_group1_o)
        else $error("request while masked");
    a_clock_out_pin: assert property (
        st_q.misc1[5] |=> pc_oe_o[2] && pc_out_o[2] == $past(st_q.cpu_clk))
        else $error("clock not on pin");
    a_normal_div2: assert property (
        !st_q.misc1[0] |=> st_q.cpu_clk != $past(st_q.cpu_clk))
        else $error("normal mode not divide by two");
    a_slow32_hold: assert property (
        st_q.misc1[2:0] == 3'b111 && st_q.div_cnt < 5'h0F |=> st_q.cpu_clk == $past(st_q.cpu_clk))
        else $error("slow divider toggled early");
    a_spi_disable: assert property (
        wr_i && addr_i == `PMC_OFS_MISC2 |=> spi_mosi_disable_o == $past(wdata_i[3]) &&
        spi_miso_disable_o == $past(wdata_i[2]))
        else $error("spi disable bits wrong");
    a_ss_internal: assert property (
        st_q.misc2[1] |=> spi_ss_o == $past(st_q.misc2[0]))
        else $error("internal slave select ignored");
    a_rsvd_zero: assert property (
        rd_i && addr_i == `PMC_OFS_MISC2 |=> rdata_o[7:4] == 4'h0)
        else $error("reserved bits not zero");
    a_data_read: assert property (
        rd_i && addr_i == `PMC_OFS_PA_DATA |=>
        rdata_o == (($past(st_q.dir[0]) & $past(st_q.data[0])) |
                    (~$past(st_q.dir[0]) & $past(st_q.filt[0]))))
        else $error("data read mixes wrong");
    a_fall_pulse: assert property (
        st_q.misc1[4:3] == 2'b10 && !irq_mask_i &&
        |(~st_q.dir[0] & st_q.opt[0] & st_q.prev[0] & ~st_q.filt[0]) |=> ext_irq_group0_o)
        else $error("falling edge request missing");
    a_ss_from_pin: assert property (
        !st_q.misc2[1] |=> spi_ss_o == $past(st_q.filt[1][7]))
        else $error("slave select not from pin");
    a_rdata_idle: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not cleared");

    c_irq_group0: cover property (ext_irq_group0_o);
    c_irq_group1: cover property (ext_irq_group1_o);
    c_clock_out: cover property (st_q.misc1[5] && pc_oe_o[2]);
    c_ss_internal: cover property (st_q.misc2[1] && spi_ss_o);
    c_slow_clock: cover property (st_q.misc1[0] && st_q.misc1[2:1] == 2'b11 && $rose(cpu_clk_o));

endmodule : pmc_port_ctrl
`default_nettype wire

// ### dv/pmc_pin_model.sv
// Pad-side model of one 8-bit port: design drive, outside drivers, pull-ups
`timescale 1ns/100ps
`default_nettype none
module pmc_pin_model (
    // Clock
    input wire logic clk_i,
    // Design side
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pullup_i,
    // Outside drivers
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    // Resolved pad levels
    output logic [7:0] pin_o
);
    logic [7:0] wander_q = 8'h55;

    // Undriven pads toggle every cycle, so the pin filter holds a floating input at its last level
    always_ff @(posedge clk_i) begin
        wander_q <= ~wander_q;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_val_i[i];
            end else if (pullup_i[i]) begin
                pin_o[i] = 1'b1;
            end else begin
                pin_o[i] = wander_q[i];
            end
        end
    end
endmodule : pmc_pin_model
`default_nettype wire

// ### dv/pmc_port_ctrl_bench.sv
// Self-checking bench for the port configuration block
`timescale 1ns/100ps
`default_nettype none
module pmc_port_ctrl_bench;
    localparam logic [23:0] ROWS [18] = '{24'h01FFFF, 24'h02A5A5, 24'h053C3C, 24'h06FFFF,
        24'h095A5A, 24'h0AFFAF, 24'h40FF0F, 24'h40A505, 24'h03FF00, 24'h20DADA, 24'h010000,
        24'h020000, 24'h050000, 24'h060000, 24'h090000, 24'h0A0000, 24'h200000, 24'h400000};
    localparam logic [7:0] REG_OFS [11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08,
        8'h09, 8'h0A, 8'h20, 8'h40};
    localparam logic [7:0] CLK_M1 [5] = '{8'h20, 8'h21, 8'h25, 8'h23, 8'h27};
    localparam int CLK_HALF [5] = '{1, 2, 4, 8, 16};
    // Control-two value, slave-select pin, then mosi/miso disable and select
    localparam logic [7:0] SPI_ROWS [6] = '{8'h8D, 8'h4B, 8'h31, 8'h28, 8'h09, 8'h00};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic irq_mask_i = 1'b1;
    logic strap = 1'b0;
    logic [7:0] rd_val;
    logic [2:0][7:0] ext_en = 24'h01C101;
    logic [2:0][7:0] ext_val = 24'h018101;
    wire [7:0] rdata_o;
    wire [2:0][7:0] pin_in, pin_out, pin_oe, pin_pu;
    wire irq0, irq1, cpu_clk_o, mosi_dis, miso_dis, ss;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int hits [2];
    logic [1:0] last_lvl;

    pmc_port_ctrl dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_mask_i(irq_mask_i),
        .irq_source_option_bit_i(strap),
        .pa_in_i(pin_in[0]), .pa_out_o(pin_out[0]), .pa_oe_o(pin_oe[0]), .pa_pullup_o(pin_pu[0]),
        .pb_in_i(pin_in[1]), .pb_out_o(pin_out[1]), .pb_oe_o(pin_oe[1]), .pb_pullup_o(pin_pu[1]),
        .pc_in_i(pin_in[2]), .pc_out_o(pin_out[2]), .pc_oe_o(pin_oe[2]), .pc_pullup_o(pin_pu[2]),
        .ext_irq_group0_o(irq0), .ext_irq_group1_o(irq1), .cpu_clk_o(cpu_clk_o),
        .spi_mosi_disable_o(mosi_dis), .spi_miso_disable_o(miso_dis), .spi_ss_o(ss)
    );

    for (genvar p = 0; p < 3; p++) begin : g_pins
        pmc_pin_model pins (.clk_i(clk_i), .out_i(pin_out[p]), .oe_i(pin_oe[p]),
            .pullup_i(pin_pu[p]), .ext_en_i(ext_en[p]), .ext_val_i(ext_val[p]),
            .pin_o(pin_in[p]));
    end

    initial forever #4 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        rd_val = rdata_o;
    endtask : reg_rd

    task automatic set_mask(input logic m);
        @(posedge clk_i);
        irq_mask_i <= m;
    endtask : set_mask

    // Moves bit 0 of one port, then counts request cycles on both groups
    task automatic pin_step(input int p, input logic v);
        @(posedge clk_i);
        ext_val[p][0] <= v;
        hits = '{0, 0};
        repeat (12) begin
            @(negedge clk_i);
            last_lvl = {irq1, irq0};
            hits[0] += int'(irq0 === 1'b1);
            hits[1] += int'(irq1 === 1'b1);
        end
    endtask : pin_step

    // Third pass only: the first is partial and already holds any effect of the ratio change
    task automatic half_period(output int n);
        logic v;
        @(negedge clk_i);
        repeat (3) begin
            v = cpu_clk_o;
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (cpu_clk_o === v && n < 40);
        end
    endtask : half_period

    task automatic test_done();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int h;
        int q;
        logic pv;
        repeat (9) @(posedge clk_i);
        @(negedge clk_i);
        check("reset outputs", {pin_oe | pin_pu, 2'b00, irq0, irq1, cpu_clk_o, mosi_dis,
            miso_dis, ss}, 0);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Let the pin filters settle so data reads see steady pad levels
        repeat (4) @(posedge clk_i);
        foreach (REG_OFS[k]) begin
            reg_rd(REG_OFS[k]);
            q = 2 - int'(REG_OFS[k][3:2]);
            pv = REG_OFS[k] < 8'h0C && REG_OFS[k][1:0] == 2'b00;
            check("reset value", rd_val, pv ? ext_val[q] & ext_en[q] : 8'h00);
        end
        foreach (ROWS[k]) begin
            reg_wr(ROWS[k][23:16], ROWS[k][15:8]);
            reg_rd(ROWS[k][23:16]);
            check("register readback", rd_val, ROWS[k][7:0]);
            @(negedge clk_i);
            check("read data idle", rdata_o, 0);
        end
        set_mask(1'b0);
        reg_wr(8'h20, 8'hFF);
        reg_rd(8'h20);
        check("unmasked sensitivity write", rd_val, 8'h27);
        reg_wr(8'h0A, 8'h01);
        reg_wr(8'h06, 8'h01);
        for (int c = 0; c < 4; c++) begin
            for (int g = 0; g < 2; g++) begin
                set_mask(1'b1);
                reg_wr(8'h20, 8'(c << (g ? 6 : 3)));
                irq_mask_i <= 1'b0;
                pin_step(g, 1'b0);
                if (c == 0) check("irq held low", last_lvl[g], 1);
                else check("irq on fall", hits[g], c / 2);
                check("irq other group", hits[1 - g], 0);
                pin_step(g, 1'b1);
                if (c == 0) check("irq released", last_lvl[g], 0);
                else check("irq on rise", hits[g], c % 2);
            end
        end
        set_mask(1'b1);
        reg_wr(8'h20, 8'h18);
        pin_step(0, 1'b0);
        check("irq while masked", hits[0], 0);
        pin_step(0, 1'b1);
        set_mask(1'b0);
        reg_wr(8'h0A, 8'h00);
        pin_step(0, 1'b0);
        check("irq floating input", hits[0], 0);
        set_mask(1'b1);
        reg_wr(8'h20, 8'h90);
        reg_wr(8'h02, 8'h01);
        set_mask(1'b0);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i);
            strap <= 1'(s);
            pin_step(2, 1'b0);
            check("strap chosen group", hits[s], 1);
            check("strap other group", hits[1 - s], 0);
            pin_step(2, 1'b1);
        end
        foreach (CLK_M1[k]) begin
            reg_wr(8'h20, CLK_M1[k]);
            half_period(h);
            check("cpu clock half period", h, CLK_HALF[k]);
            pv = cpu_clk_o;
            @(negedge clk_i);
            check("clock pin", {pin_oe[2][2], pin_out[2][2]}, {1'b1, pv});
        end
        reg_wr(8'h20, 8'h00);
        repeat (3) @(negedge clk_i);
        check("clock pin released", pin_oe[2][2], 0);
        foreach (SPI_ROWS[k]) begin
            reg_wr(8'h40, {4'h0, SPI_ROWS[k][7:4]});
            ext_val[1][7] <= SPI_ROWS[k][3];
            repeat (8) @(negedge clk_i);
            check("spi control", {mosi_dis, miso_dis, ss}, SPI_ROWS[k][2:0]);
        end
        reg_wr(8'h05, 8'h0F);
        ext_val[1][7] <= 1'b1;
        reg_wr(8'h06, 8'h33);
        reg_wr(8'h04, 8'h05);
        repeat (8) @(negedge clk_i);
        check("port b enables", {pin_pu[1], pin_oe[1]}, 16'h300B);
        check("port b drive", pin_out[1], 8'h01);
        reg_rd(8'h04);
        check("port b read", rd_val, 8'hB5);
        reg_wr(8'h04, 8'h45);
        reg_rd(8'h04);
        check("input latch hidden", rd_val, 8'hB5);
        reg_wr(8'h05, 8'hFF);
        reg_rd(8'h04);
        check("latch kept", rd_val, 8'h45);
        reg_wr(8'h0A, 8'hFF);
        reg_wr(8'h09, 8'h50);
        reg_wr(8'h08, 8'h00);
        repeat (4) @(negedge clk_i);
        check("port a true open drain", {pin_pu[0], pin_oe[0]}, 16'hAF50);
        reg_wr(8'h08, 8'h50);
        repeat (4) @(negedge clk_i);
        check("port a open drain high", {pin_oe[0], pin_out[0]}, 16'h0000);
        test_done();
    end
endmodule : pmc_port_ctrl_bench
`default_nettype wire
